// ===== core/osd_char_map.vh
`ifndef OSD_CHAR_MAP_VH
`define OSD_CHAR_MAP_VH

// Register offsets on the plain register port
`define ADDR_OUT_DELAY      4'h0
`define ADDR_PAGE_SEL       4'h1
`define ADDR_FONT_CFG       4'h2
`define ADDR_HORIZ_DELAY    4'h3
`define ADDR_VERT_DELAY     4'h4
`define ADDR_STATUS         4'h5

// Field positions
`define OUT_DELAY_MSB       2
`define LOWER_PAGE_MSB      2
`define UPPER_PAGE_LSB      4
`define UPPER_PAGE_MSB      6
`define NARROW_FONT_BIT     0
`define EDGE_MODE_LSB       1
`define EDGE_MODE_MSB       2

// Reset values
`define RST_OUT_DELAY       3'h0
`define RST_LOWER_PAGE      3'h0
`define RST_UPPER_PAGE      3'h1
`define RST_FONT_CFG        3'h0
`define RST_HORIZ_DELAY     8'h00
`define RST_VERT_DELAY      8'h00

// Edge modes
`define EDGE_NONE           2'h0
`define EDGE_BORDER         2'h1
`define EDGE_SHADOW         2'h2

// Character codes
`define CODE_BLANK          8'h00
`define CODE_FILL           8'h7f
`define CODE_MULTI_FIRST    8'h01
`define CODE_MULTI_LAST     8'h10

// Frame geometry and timing counts
`define H_FIXED_DOTS        11'h02f
`define PHASE_PULSE_DOTS    11'h004
`define V_FIXED_LINES       10'h001
`define FRAME_COLS          5'h1e
`define FRAME_ROWS          4'hf
`define CHAR_LINES_LAST     5'h11
`define DOT_LAST_WIDE       4'hb
`define DOT_LAST_NARROW     4'h9
`define DELAY_TAPS          7

`endif

// ===== core/char_rom_mapper.v
`timescale 1ns/1ps
`default_nettype none
`include "osd_char_map.vh"

module char_rom_mapper (
    // Logical code and bank pages
    input  wire [7:0] code_i,
    input  wire [2:0] lower_sel_i,
    input  wire [2:0] upper_sel_i,
    // Physical pattern address and code class
    output wire [8:0] phys_addr_o,
    output wire       is_blank_o,
    output wire       is_fill_o,
    output wire       is_multi_o,
    output wire       is_reserved_o
);

    // Page n of the 64-entry pages starts at (n+2)*64
    function [2:0] page_base;
        input [2:0] sel;
        begin
            page_base = sel + 3'h2;
        end
    endfunction

    function reserved_sel;
        input [2:0] sel;
        begin
            reserved_sel = sel[2] & sel[1];
        end
    endfunction

    wire       upper_bank = code_i[6];
    wire [2:0] sel        = upper_bank ? upper_sel_i : lower_sel_i;

    assign phys_addr_o = code_i[7] ? {page_base(sel), code_i[5:0]}
                                   : {2'h0, code_i[6:0]};
    assign is_reserved_o = code_i[7] &
                           (upper_bank ? reserved_sel(upper_sel_i)
                                       : reserved_sel(lower_sel_i));
    assign is_blank_o = (code_i == `CODE_BLANK);
    assign is_fill_o  = (code_i == `CODE_FILL);
    assign is_multi_o = (code_i >= `CODE_MULTI_FIRST) &&
                        (code_i <= `CODE_MULTI_LAST);

endmodule // char_rom_mapper
`default_nettype wire

// ===== core/pixel_delay_line.v
`timescale 1ns/1ps
`default_nettype none
`include "osd_char_map.vh"

module pixel_delay_line (
    // Clock and reset
    input  wire       clk_i,
    input  wire       reset_n_i,
    // Pixel stream {r,g,b,fast blank}
    input  wire [3:0] pix_i,
    input  wire [2:0] delay_sel_i,
    output reg  [3:0] pix_o
);

    reg [3:0] tap_q [0:`DELAY_TAPS-1];

    genvar i;
    generate
        for (i = 0; i < `DELAY_TAPS; i = i + 1) begin : g_tap
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    tap_q[i] <= 4'h0;
                end else if (i == 0) begin
                    tap_q[i] <= pix_i;
                end else begin
                    tap_q[i] <= tap_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // All four bits share one tap so they stay aligned
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pix_o <= 4'h0;
        end else if (delay_sel_i == 3'h0) begin
            pix_o <= pix_i;
        end else begin
            pix_o <= tap_q[delay_sel_i - 3'h1];
        end
    end

endmodule // pixel_delay_line
`default_nettype wire

// ===== core/osd_char_render.v
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "osd_char_map.vh"

module osd_char_render (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [7:0]  reg_rdata_o,
    // Sync inputs, active high at leading edge
    input  wire        hsync_i,
    input  wire        vsync_i,
    // Display memory cell lookup
    output reg  [3:0]  row_o,
    output reg  [4:0]  col_o,
    input  wire [7:0]  char_code_i,
    input  wire [2:0]  char_color_i,
    input  wire        row_double_width_i,
    // Pattern store lookup
    output wire [8:0]  rom_addr_o,
    output reg  [4:0]  rom_line_o,
    input  wire [11:0] font_r_i,
    input  wire [11:0] font_g_i,
    input  wire [11:0] font_b_i,
    input  wire [11:0] font_opaque_i,
    input  wire [11:0] font_above_i,
    input  wire [11:0] font_below_i,
    // Video outputs
    output wire        red_o,
    output wire        green_o,
    output wire        blue_o,
    output wire        fast_blank_out_o
);

    // Registers
    reg [2:0] out_delay_sel_q;
    reg [2:0] lower_bank_page_sel_q;
    reg [2:0] upper_bank_page_sel_q;
    reg       narrow_font_select_q;
    reg [1:0] edge_mode_q;
    reg [7:0] horiz_delay_value_q;
    reg [7:0] vert_delay_value_q;

    // Frame timing state
    reg        hsync_q;
    reg        vsync_q;
    reg [10:0] hcnt_q;
    reg [9:0]  vline_q;
    reg        h_act_q;
    reg        v_act_q;
    reg        v_done_q;
    reg [3:0]  dot_q;
    reg        half_q;
    reg [3:0]  pix_q;

    wire h_lead = hsync_i & ~hsync_q;
    wire v_lead = vsync_i & ~vsync_q;

    wire [10:0] hstart = `H_FIXED_DOTS + `PHASE_PULSE_DOTS +
                         {3'h0, horiz_delay_value_q};
    wire [9:0]  vstart = `V_FIXED_LINES + {2'h0, vert_delay_value_q};
    wire [3:0]  dot_last = narrow_font_select_q ? `DOT_LAST_NARROW
                                                : `DOT_LAST_WIDE;
    wire [9:0]  vline_next = vline_q + 10'h001;

    // Register writes
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_delay_sel_q       <= `RST_OUT_DELAY;
            lower_bank_page_sel_q <= `RST_LOWER_PAGE;
            upper_bank_page_sel_q <= `RST_UPPER_PAGE;
            narrow_font_select_q  <= 1'b0;
            edge_mode_q           <= `EDGE_NONE;
            horiz_delay_value_q   <= `RST_HORIZ_DELAY;
            vert_delay_value_q    <= `RST_VERT_DELAY;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `ADDR_OUT_DELAY: begin
                    out_delay_sel_q <= reg_wdata_i[`OUT_DELAY_MSB:0];
                end
                `ADDR_PAGE_SEL: begin
                    lower_bank_page_sel_q <= reg_wdata_i[`LOWER_PAGE_MSB:0];
                    upper_bank_page_sel_q <= reg_wdata_i[`UPPER_PAGE_MSB:`UPPER_PAGE_LSB];
                end
                `ADDR_FONT_CFG: begin
                    narrow_font_select_q <= reg_wdata_i[`NARROW_FONT_BIT];
                    edge_mode_q          <= reg_wdata_i[`EDGE_MODE_MSB:`EDGE_MODE_LSB];
                end
                `ADDR_HORIZ_DELAY: begin
                    horiz_delay_value_q <= reg_wdata_i;
                end
                `ADDR_VERT_DELAY: begin
                    vert_delay_value_q <= reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads, data in the following cycle only
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `ADDR_OUT_DELAY:   reg_rdata_o <= {5'h00, out_delay_sel_q};
                `ADDR_PAGE_SEL:    reg_rdata_o <= {1'b0, upper_bank_page_sel_q,
                                                   1'b0, lower_bank_page_sel_q};
                `ADDR_FONT_CFG:    reg_rdata_o <= {5'h00, edge_mode_q, narrow_font_select_q};
                `ADDR_HORIZ_DELAY: reg_rdata_o <= horiz_delay_value_q;
                `ADDR_VERT_DELAY:  reg_rdata_o <= vert_delay_value_q;
                `ADDR_STATUS:      reg_rdata_o <= {row_o, 1'b0, v_done_q, v_act_q, h_act_q};
                default:           reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Vertical placement, counted in scan lines from the vsync edge
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hsync_q    <= 1'b0;
            vsync_q    <= 1'b0;
            vline_q    <= 10'h000;
            v_act_q    <= 1'b0;
            v_done_q   <= 1'b0;
            row_o      <= 4'h0;
            rom_line_o <= 5'h00;
        end else begin
            hsync_q <= hsync_i;
            vsync_q <= vsync_i;
            if (v_lead) begin
                // Frames overrunning the next vsync are cut here
                vline_q    <= 10'h000;
                v_act_q    <= 1'b0;
                v_done_q   <= 1'b0;
                row_o      <= 4'h0;
                rom_line_o <= 5'h00;
            end else if (h_lead) begin
                if (vline_q != 10'h3ff) begin
                    vline_q <= vline_next;
                end
                if (v_act_q) begin
                    if (rom_line_o == `CHAR_LINES_LAST) begin
                        rom_line_o <= 5'h00;
                        if (row_o == `FRAME_ROWS - 4'h1) begin
                            v_act_q  <= 1'b0;
                            v_done_q <= 1'b1;
                        end else begin
                            row_o <= row_o + 4'h1;
                        end
                    end else begin
                        rom_line_o <= rom_line_o + 5'h01;
                    end
                end else if (!v_done_q && vline_next == vstart) begin
                    v_act_q    <= 1'b1;
                    row_o      <= 4'h0;
                    rom_line_o <= 5'h00;
                end
            end
        end
    end

    // Horizontal placement and dot stepping
    wire [4:0] col_step = row_double_width_i ? 5'h02 : 5'h01;
    wire [4:0] col_next = col_o + col_step;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hcnt_q  <= 11'h000;
            h_act_q <= 1'b0;
            col_o   <= 5'h00;
            dot_q   <= 4'h0;
            half_q  <= 1'b0;
        end else if (h_lead) begin
            hcnt_q  <= 11'h000;
            h_act_q <= 1'b0;
            col_o   <= 5'h00;
            dot_q   <= 4'h0;
            half_q  <= 1'b0;
        end else begin
            if (hcnt_q != 11'h7ff) begin
                hcnt_q <= hcnt_q + 11'h001;
            end
            if (!h_act_q) begin
                if (v_act_q && hcnt_q + 11'h001 == hstart) begin
                    h_act_q <= 1'b1;
                    col_o   <= 5'h00;
                    dot_q   <= 4'h0;
                    half_q  <= 1'b0;
                end
            end else begin
                // Double width repeats each dot for two pixel clocks
                half_q <= row_double_width_i ? ~half_q : 1'b0;
                if (!row_double_width_i || half_q) begin
                    if (dot_q == dot_last) begin
                        dot_q <= 4'h0;
                        if (col_next >= `FRAME_COLS) begin
                            h_act_q <= 1'b0;
                        end else begin
                            col_o <= col_next;
                        end
                    end else begin
                        dot_q <= dot_q + 4'h1;
                    end
                end
            end
        end
    end

    // Code to pattern address
    wire is_blank;
    wire is_fill;
    wire is_multi;
    wire is_reserved;

    char_rom_mapper u_mapper (
        .code_i        (char_code_i),
        .lower_sel_i   (lower_bank_page_sel_q),
        .upper_sel_i   (upper_bank_page_sel_q),
        .phys_addr_o   (rom_addr_o),
        .is_blank_o    (is_blank),
        .is_fill_o     (is_fill),
        .is_multi_o    (is_multi),
        .is_reserved_o (is_reserved)
    );

    // Forced patterns override whatever the store returns
    wire        no_dots  = is_blank | is_reserved;
    wire [11:0] mono     = is_fill ? 12'hfff : (no_dots ? 12'h000 : font_r_i);
    wire [11:0] mono_up  = is_fill ? 12'hfff : (no_dots ? 12'h000 : font_above_i);
    wire [11:0] mono_dn  = is_fill ? 12'hfff : (no_dots ? 12'h000 : font_below_i);

    // Bit 11 is the leftmost dot
    wire [3:0] idx   = 4'hb - dot_q;
    wire       dot   = mono[idx];
    wire       left  = (dot_q != 4'h0) ? mono[idx + 4'h1] : 1'b0;
    wire       right = (dot_q != 4'hb) ? mono[idx - 4'h1] : 1'b0;
    wire       up    = mono_up[idx];
    wire       down  = mono_dn[idx];
    wire       up_l  = (dot_q != 4'h0) ? mono_up[idx + 4'h1] : 1'b0;

    reg edge_on;
    always @* begin
        case (edge_mode_q)
            `EDGE_BORDER: edge_on = ~dot & (left | right | up | down);
            `EDGE_SHADOW: edge_on = ~dot & (left | up | up_l);
            default:      edge_on = 1'b0;
        endcase
    end

    reg [3:0] pix_d;
    always @* begin
        if (!(h_act_q && v_act_q)) begin
            pix_d = 4'h0;
        end else if (is_multi) begin
            // Opaque plane gives the ninth, transparent, choice
            pix_d = font_opaque_i[idx] ? {font_r_i[idx], font_g_i[idx], font_b_i[idx], 1'b1}
                                       : 4'h0;
        end else if (dot) begin
            pix_d = {char_color_i, 1'b1};
        end else if (edge_on) begin
            pix_d = 4'h1;
        end else begin
            pix_d = 4'h0;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pix_q <= 4'h0;
        end else begin
            pix_q <= pix_d;
        end
    end

    wire [3:0] pix_out;

    pixel_delay_line u_delay (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .pix_i       (pix_q),
        .delay_sel_i (out_delay_sel_q),
        .pix_o       (pix_out)
    );

    assign red_o            = pix_out[3];
    assign green_o          = pix_out[2];
    assign blue_o           = pix_out[1];
    assign fast_blank_out_o = pix_out[0];

endmodule // osd_char_render
`default_nettype wire

// ===== testbench/video_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module video_side_model (
    // Lookups from the block
    input  wire logic [7:0]  cell_code_i,
    input  wire logic [8:0]  rom_addr_i,
    // Answers to the block
    output logic      [7:0]  char_code_o,
    output logic      [11:0] font_r_o,
    output logic      [11:0] font_g_o,
    output logic      [11:0] font_b_o,
    output logic      [11:0] font_opaque_o,
    output logic      [11:0] font_above_o,
    output logic      [11:0] font_below_o
);
    // One code in every cell keeps expected dot counts simple
    assign char_code_o   = cell_code_i;
    // Pattern holds its own address, so a wrong lookup shifts the counts
    assign font_r_o      = {3'b101, rom_addr_i};
    assign font_g_o      = ~font_r_o;
    assign font_b_o      = 12'h0f0;
    // Rightmost dot of every multi-colour cell is transparent
    assign font_opaque_o = 12'hffe;
    assign font_above_o  = font_r_o;
    assign font_below_o  = font_r_o;
endmodule // video_side_model
`default_nettype wire

// ===== testbench/osd_char_render_sva.sv
`timescale 1ns/1ps
`default_nettype none
module osd_char_render_sva (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    // Video side
    input wire logic       hsync_i,
    input wire logic       vsync_i,
    input wire logic [4:0] col_o,
    input wire logic [7:0] char_code_i,
    input wire logic       row_double_width_i,
    input wire logic [8:0] rom_addr_o,
    input wire logic       fast_blank_out_o
);
    logic [2:0] lower_q;
    logic [2:0] upper_q;
    logic [2:0] sel;

    // Shadow of the page selects so the mapping is judged live
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lower_q <= 3'h0;
            upper_q <= 3'h1;
        end else if (reg_write_i && reg_addr_i == 4'h1) begin
            lower_q <= reg_wdata_i[2:0];
            upper_q <= reg_wdata_i[6:4];
        end
    end
    assign sel = char_code_i[6] ? upper_q : lower_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    rdata_idle_a:
        assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its slot");
    delay_readback_a:
        assert property (reg_write_i && reg_addr_i == 4'h0 ##1 reg_read_i && reg_addr_i == 4'h0
            |=> (reg_rdata_o & 8'h07) == ($past(reg_wdata_i, 2) & 8'h07))
        else $error("delay field readback wrong");
    page_readback_a:
        assert property (reg_write_i && reg_addr_i == 4'h1 ##1 reg_read_i && reg_addr_i == 4'h1
            |=> (reg_rdata_o & 8'h77) == ($past(reg_wdata_i, 2) & 8'h77))
        else $error("page select readback wrong");
    low_bank_a:
        assert property (!char_code_i[7] |-> rom_addr_o == {2'b00, char_code_i[6:0]})
        else $error("low bank address wrong");
    switch_bank_a:
        assert property (char_code_i[7] && sel < 3'h6
            |-> rom_addr_o == {sel + 3'h2, char_code_i[5:0]})
        else $error("switchable bank address wrong");
    double_even_a:
        assert property (row_double_width_i && $past(row_double_width_i) && $changed(col_o)
            |-> !col_o[0])
        else $error("odd column in double width row");
    hsync_quiet_a:
        assert property ($rose(hsync_i) |=> !fast_blank_out_o [*8])
        else $error("dots too soon after line sync");
    vsync_quiet_a:
        assert property ($rose(vsync_i) && !hsync_i |=> !fast_blank_out_o [*8])
        else $error("dots too soon after frame sync");
endmodule // osd_char_render_sva

bind osd_char_render osd_char_render_sva osd_char_render_sva_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .hsync_i(hsync_i), .vsync_i(vsync_i), .col_o(col_o),
    .char_code_i(char_code_i), .row_double_width_i(row_double_width_i),
    .rom_addr_o(rom_addr_o), .fast_blank_out_o(fast_blank_out_o));
`default_nettype wire

// ===== testbench/osd_char_render_bench.sv
`timescale 1ns/1ps
`default_nettype none
module osd_char_render_bench;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_write_i = 1'b0;
    logic        reg_read_i = 1'b0;
    logic        hsync_i = 1'b0;
    logic        vsync_i = 1'b0;
    logic [7:0]  code = 8'h7f;
    logic [2:0]  color = 3'h7;
    logic        dbl = 1'b0;
    logic [7:0]  rdata, ccode;
    logic [8:0]  rom_addr;
    logic [11:0] fr, fg, fb, fo, fa, fw;
    logic        red, green, blue, fblank;
    logic [3:0]  row;
    logic [4:0]  rline;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          first, nfb, nr, ng, nb;
    logic [7:0]  v;

    always #10 clk_i = ~clk_i;

    osd_char_render osd_char_render_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(rdata), .hsync_i(hsync_i), .vsync_i(vsync_i), .row_o(row), .col_o(),
        .char_code_i(ccode), .char_color_i(color), .row_double_width_i(dbl),
        .rom_addr_o(rom_addr), .rom_line_o(rline), .font_r_i(fr), .font_g_i(fg), .font_b_i(fb),
        .font_opaque_i(fo), .font_above_i(fa), .font_below_i(fw), .red_o(red),
        .green_o(green), .blue_o(blue), .fast_blank_out_o(fblank));

    video_side_model video_side_model_inst (
        .cell_code_i(code), .rom_addr_i(rom_addr), .char_code_o(ccode), .font_r_o(fr),
        .font_g_o(fg), .font_b_o(fb), .font_opaque_o(fo), .font_above_o(fa),
        .font_below_o(fw));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_write_i <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 d = rdata;
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        wr(a, d);
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 q = rdata;
    endtask

    // Frames hold only a few lines, each cut short by the next vsync
    task automatic frame();
        @(posedge clk_i);
        vsync_i <= 1'b1;
        @(posedge clk_i);
        vsync_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic line();
        first = 0;
        nfb = 0;
        nr = 0;
        ng = 0;
        nb = 0;
        @(posedge clk_i);
        hsync_i <= 1'b1;
        @(posedge clk_i);
        hsync_i <= 1'b0;
        for (int n = 1; n <= 720; n++) begin
            @(posedge clk_i);
            #1;
            if (fblank === 1'b1 && first == 0) first = n;
            nfb += (fblank === 1'b1);
            nr += (red === 1'b1);
            ng += (green === 1'b1);
            nb += (blue === 1'b1);
        end
        // Return on an edge so callers drive inputs there
        @(posedge clk_i);
    endtask

    task automatic t_regs();
        rd(4'h0, v); check(v, 8'h00);
        rd(4'h1, v); check(v, 8'h10);
        wr_rd(4'h0, 8'hfd, v); check(v & 8'h07, 8'h05);
        rd(4'hf, v); check(v, 8'h00);
        $display("done regs");
    endtask

    task automatic t_map();
        for (int s = 0; s < 6; s++) begin
            wr_rd(4'h1, {1'b0, 3'(s), 1'b0, 3'(5 - s)}, v);
            check(v & 8'h77, {1'b0, 3'(s), 1'b0, 3'(5 - s)});
            @(posedge clk_i);
            code <= 8'h80 | 8'(s);
            @(negedge clk_i);
            check(rom_addr, {3'(7 - s), 6'(s)});
            @(posedge clk_i);
            code <= 8'hc0 | 8'(s);
            @(negedge clk_i);
            check(rom_addr, {3'(s + 2), 6'(s)});
        end
        @(posedge clk_i);
        code <= 8'h3c;
        @(negedge clk_i);
        check(rom_addr, 9'h03c);
        wr(4'h1, 8'h10);
        $display("done map");
    endtask

    task automatic t_timing(input logic [7:0] hd, input logic [2:0] d);
        code <= 8'h7f;
        wr(4'h3, hd);
        wr(4'h0, {5'h00, d});
        frame();
        line();
        check(first, 53 + hd + d);
        check(nfb, 360);
        check(nr, 360);
        check(nb, 360);
        $display("done timing");
    endtask

    task automatic t_vdelay();
        wr(4'h4, 8'h02);
        frame();
        repeat (2) begin
            line(); check(nfb, 0);
        end
        line(); check(nfb, 360);
        line(); check(rline, 5'h01);
        check(row, 4'h0);
        wr(4'h4, 8'h00);
        $display("done vdelay");
    endtask

    task automatic t_font();
        wr(4'h2, 8'h01);
        frame(); line(); check(nfb, 300);
        dbl <= 1'b1;
        frame(); line(); check(nfb, 300);
        dbl <= 1'b0;
        wr(4'h2, 8'h00);
        code <= 8'h01;
        color <= 3'h4;
        frame(); line(); check(ng, 270);
        check(nr, 60);
        check(nb, 120);
        check(nfb, 330);
        code <= 8'h00;
        frame(); line(); check(nfb, 0);
        wr(4'h1, 8'h16);
        code <= 8'h85;
        frame(); line(); check(nr, 0);
        $display("done font");
    endtask

    // Pattern a20 has dots 0, 2 and 6: four blank dots touch them, three lie right of them
    task automatic t_edge();
        wr(4'h2, 8'h02);
        code <= 8'h20;
        frame(); line(); check(nfb, 210);
        check(nr, 90);
        wr(4'h2, 8'h04);
        frame(); line(); check(nfb, 180);
        wr(4'h2, 8'h00);
        rd(4'h5, v); check(v, 8'h02);
        $display("done edge");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Whole run needs about 9500 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_map();
        t_timing(8'h00, 3'h0);
        t_timing(8'h09, 3'h5);
        t_vdelay();
        t_font();
        t_edge();
        wrap_up();
    end
endmodule // osd_char_render_bench
`default_nettype wire
